// ==== hdl/csf_pkg.sv ====
// constants, register map and state type of the command status block
package csf_pkg;
   // ==========================================
   // register indices on the register port
   localparam logic [2:0]  CSF_REG_IEN     = 3'h0;
   localparam logic [2:0]  CSF_REG_CAUSE   = 3'h1;
   localparam logic [2:0]  CSF_REG_VEC     = 3'h2;
   localparam logic [2:0]  CSF_REG_CAP     = 3'h3;
   localparam logic [2:0]  CSF_REG_STS     = 3'h4;
   localparam logic [2:0]  CSF_REG_DATA    = 3'h5;
   // ==========================================
   // status_reg field positions
   localparam int unsigned CSF_STS_RETRY   = 1;
   localparam int unsigned CSF_STS_EXPECT  = 3;
   localparam int unsigned CSF_STS_AVAIL   = 4;
   localparam int unsigned CSF_STS_GO      = 5;
   localparam int unsigned CSF_STS_CMDRDY  = 6;
   localparam int unsigned CSF_STS_VALID   = 7;
   // ==========================================
   // irq_enable_control and irq_cause_reg fields
   localparam int unsigned CSF_IRQ_RESP    = 0;
   localparam int unsigned CSF_IRQ_STSV    = 1;
   localparam int unsigned CSF_IRQ_OWNER   = 2;
   localparam int unsigned CSF_IRQ_CMDRDY  = 7;
   localparam int unsigned CSF_IEN_TRIG    = 3;
   localparam int unsigned CSF_IEN_MASTER  = 31;
   localparam logic [31:0] CSF_IEN_RST     = 32'h0000_0008;
   localparam logic [31:0] CSF_IEN_WMASK   = 32'h8000_009f;
   localparam logic [7:0]  CSF_CAUSE_MASK  = 8'h87;
   localparam logic [31:0] CSF_CAPS        = 32'h0000_00ff;
   localparam logic [7:0]  CSF_EMPTY_BYTE  = 8'hff;
   // ==========================================
   // command header: big-endian length field
   localparam int unsigned CSF_LEN_POS     = 2;
   localparam int unsigned CSF_HDR_BYTES   = 6;
   // ==========================================
   // serial irq framing, in link clocks
   localparam logic [2:0]  CSF_START_MIN   = 3'h4;
   localparam logic [1:0]  CSF_SLOT_CLKS   = 2'h3;
   localparam logic [4:0]  CSF_NUM_SLOTS   = 5'h10;
   localparam logic [1:0]  CSF_TRIG_LOW    = 2'h1;
   localparam logic [1:0]  CSF_TRIG_FALL   = 2'h3;

   typedef enum logic [2:0] {
      CSF_IDLE, CSF_READY, CSF_RECEPTION, CSF_EXECUTION, CSF_COMPLETION
   } csf_state_t;
endpackage : csf_pkg

// ==== hdl/csf_buf_if.sv ====
// interface between the controller and the command/response buffer
`timescale 1ns/1ps
interface csf_buf_if #(parameter int unsigned AW = 8);
   logic          a_we;
   logic [AW-1:0] a_addr;
   logic [7:0]    a_wdata;
   logic [7:0]    a_rdata;
   logic          b_we;
   logic [AW-1:0] b_addr;
   logic [7:0]    b_wdata;
   logic [7:0]    b_rdata;
   modport ctl (output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
                input  a_rdata, b_rdata);
   modport mem (input  a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
                output a_rdata, b_rdata);
endinterface : csf_buf_if

// ==== hdl/csf_buf_mem.sv ====
// two-port byte buffer holding the command and the response
`timescale 1ns/1ps
module csf_buf_mem #(
   parameter int unsigned AW = 8
) (
   input wire logic core_clk,
   csf_buf_if.mem   bus
);
   logic [7:0] mem_q [2**AW];

   // ==========================================
   // write ports, executor port wins on a clash
   always_ff @(posedge core_clk) begin
      if (bus.a_we) begin
         mem_q[bus.a_addr] <= bus.a_wdata;
      end
      if (bus.b_we) begin
         mem_q[bus.b_addr] <= bus.b_wdata;
      end
   end

   // registered read data on both ports
   always_ff @(posedge core_clk) begin
      bus.a_rdata <= mem_q[bus.a_addr];
      bus.b_rdata <= mem_q[bus.b_addr];
   end
endmodule : csf_buf_mem

// ==== hdl/csf_top.sv ====
// command status state machine, interrupt logic and serial irq slot driver
// How it works
// RL1 - non-final command bytes accepted while expecting, stay in reception
// RL2 - final command byte clears the expect flag; host resends on mismatch
// RL3 - data port read without response available returns FFh, no change
// RL4 - go command with expect clear starts execution
// RL5 - command-ready write aborts reception, execution or completion to idle
// RL6 - execution done moves to completion and sets response available
// RL7 - unexpected data writes, go and retry commands are silently dropped
// RL8 - retry in completion rewinds read pointer and sets response available
// RL9 - reads return response bytes; last byte clears response available
// RL10 - command-ready after the response goes to idle
// RL11 - status write with several command bits set is ignored
// RL12 - events set cause bits; a new cause raises the irq if none pending
// RL13 - no further irq until acknowledged; causes still latch meanwhile
// RL14 - writing ones to cause bits clears them, zeros do nothing
// RL15 - causes left after an acknowledge raise a fresh irq
// RL16 - any of irq slots 1 to 15 usable, never the slots after them
// RL17 - owner-switch and response causes always present, others optional
// RL18 - low level trigger supported, schemes reported in capability bits
// RL19 - irqs held inactive while master enable is 0 or changing
// RL20 - host leaves master enable alone while an irq is active
// RL21 - one interrupt setup shared by all localities
// RL22 - host masks irqs while polling and polls once after unmasking
// RL23 - channel 1 to 15 selects the slot, 0 leaves the line undriven
// RL24 - trigger field encodes high, low, rising, falling; resets to low
// RL25 - response cause set only when response rises with status valid
// RL26 - owner-switch cause only when a grant was delayed
// RL27 - reset gives idle with flags, causes and pending irq cleared
`timescale 1ns/1ps
module csf_top import csf_pkg::*; #(
   parameter int unsigned BUF_AW = 8
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [2:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   output logic                   reg_rvalid,
   input  wire logic              exec_done,
   input  wire logic [BUF_AW:0]   exec_resp_len,
   output logic                   exec_start,
   output logic                   exec_abort,
   input  wire logic              exec_mem_we,
   input  wire logic [BUF_AW-1:0] exec_mem_addr,
   input  wire logic [7:0]        exec_mem_wdata,
   output logic      [7:0]        exec_mem_rdata,
   input  wire logic              owner_grant,
   input  wire logic              owner_delayed,
   input  wire logic              sirq_clk,
   input  wire logic              sirq_in,
   output logic                   sirq_out,
   output logic                   sirq_oe
);
   localparam logic [BUF_AW:0] DEPTH = (BUF_AW+1)'(2**BUF_AW);

   // ==========================================
   // register decode helpers
   function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
      return a == idx;
   endfunction : hit

   csf_state_t       state_q;
   logic             expect_q;
   logic             avail_q;
   logic             avail_p_q;
   logic             sv_q;
   logic             sv_p_q;
   logic             rdy_p_q;
   logic [BUF_AW:0]  cnt_q;
   logic [31:0]      len_q;
   logic [BUF_AW:0]  rptr_q;
   logic [BUF_AW:0]  rlen_q;
   logic [31:0]      ien_q;
   logic [3:0]       ch_q;
   logic [7:0]       cause_q;
   logic [7:0]       cause_d;
   logic [7:0]       ev;
   logic             irq_act_q;
   logic             rearm_q;
   logic             rd1_q;
   logic             rd1_mem_q;
   logic [31:0]      rd1_val_q;
   logic [31:0]      rd_val;
   logic [2:0]       ctl;
   logic             wr_sts;
   logic             multi;
   logic             cr_w;
   logic             go_w;
   logic             rr_w;
   logic             data_wr;
   logic             data_rd;
   logic             take_byte;
   logic [BUF_AW:0]  n_cnt;
   logic [31:0]      len_nxt;
   logic             last_byte;
   logic             rd_byte;
   logic             last_rd;
   logic             abort;
   logic             ack;
   logic             ien_chg;
   logic             cmd_rdy;

   csf_buf_if #(.AW(BUF_AW)) bif ();

   csf_buf_mem #(.AW(BUF_AW)) u_mem (
      .core_clk (core_clk),
      .bus      (bif.mem)
   );

   // ==========================================
   // status write decode, one command bit at a time
   assign wr_sts  = reg_wr && hit(reg_addr, CSF_REG_STS);
   assign ctl     = {reg_wdata[CSF_STS_CMDRDY], reg_wdata[CSF_STS_GO],
                     reg_wdata[CSF_STS_RETRY]};
   assign multi   = wr_sts && !$onehot0(ctl);                   // RL11
   assign cr_w    = wr_sts && (ctl == 3'h4);                    // RL11
   assign go_w    = wr_sts && (ctl == 3'h2);
   assign rr_w    = wr_sts && (ctl == 3'h1);
   assign data_wr = reg_wr && hit(reg_addr, CSF_REG_DATA);
   assign data_rd = reg_rd && hit(reg_addr, CSF_REG_DATA);
   assign cmd_rdy = (state_q == CSF_READY);
   assign abort   = cr_w && (state_q inside {CSF_RECEPTION, CSF_EXECUTION,
                                              CSF_COMPLETION}); // RL5

   // command byte acceptance; other data writes are dropped
   assign take_byte = data_wr && (cmd_rdy ||
                      (state_q == CSF_RECEPTION && expect_q));  // RL1 RL7
   assign n_cnt     = cmd_rdy ? (BUF_AW+1)'(1) : cnt_q + (BUF_AW+1)'(1);
   assign len_nxt   = (n_cnt > (BUF_AW+1)'(CSF_LEN_POS) &&
                       n_cnt <= (BUF_AW+1)'(CSF_HDR_BYTES)) ?
                      {len_q[23:0], reg_wdata[7:0]} : len_q;
   assign last_byte = ((n_cnt >= (BUF_AW+1)'(CSF_HDR_BYTES)) &&
                       (32'(n_cnt) == len_nxt)) || (n_cnt == DEPTH); // RL2

   // response byte consumption
   assign rd_byte = data_rd && (state_q == CSF_COMPLETION) && avail_q; // RL9
   assign last_rd = rd_byte && (rptr_q + (BUF_AW+1)'(1) >= rlen_q);

   // ==========================================
   // command state machine and status flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q  <= CSF_IDLE;                                  // RL27
         expect_q <= 1'b0;
         avail_q  <= 1'b0;
      end else begin
         unique case (state_q)
            CSF_IDLE: begin
               if (cr_w) begin
                  state_q <= CSF_READY;
               end
            end
            CSF_READY: begin
               if (take_byte) begin
                  state_q  <= CSF_RECEPTION;
                  expect_q <= !last_byte;                       // RL1
               end
            end
            CSF_RECEPTION: begin
               if (abort) begin
                  state_q  <= CSF_IDLE;                         // RL5
                  expect_q <= 1'b0;
               end else if (go_w && !expect_q) begin
                  state_q <= CSF_EXECUTION;                     // RL4
               end else if (take_byte && last_byte) begin
                  expect_q <= 1'b0;                             // RL2
               end
            end
            CSF_EXECUTION: begin
               if (abort) begin
                  state_q <= CSF_IDLE;                          // RL5
               end else if (exec_done) begin
                  state_q <= CSF_COMPLETION;                    // RL6
                  avail_q <= 1'b1;
               end
            end
            CSF_COMPLETION: begin
               if (abort) begin
                  state_q <= CSF_IDLE;                          // RL10
                  avail_q <= 1'b0;
               end else if (rr_w) begin
                  avail_q <= 1'b1;                              // RL8
               end else if (last_rd) begin
                  avail_q <= 1'b0;                              // RL9
               end
            end
         endcase
      end
   end

   // byte counter, length field, read pointer and response length
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q  <= '0;
         len_q  <= '0;
         rptr_q <= '0;
         rlen_q <= '0;
      end else begin
         if (take_byte) begin
            cnt_q <= n_cnt;
            len_q <= len_nxt;
         end
         if (state_q == CSF_EXECUTION && exec_done) begin
            rptr_q <= '0;
            rlen_q <= exec_resp_len;
         end else if (rr_w && state_q == CSF_COMPLETION) begin
            rptr_q <= '0;                                       // RL8
         end else if (rd_byte) begin
            rptr_q <= rptr_q + (BUF_AW+1)'(1);                  // RL9
         end
      end
   end

   // execution start and abort pulses to the executor
   always_ff @(posedge core_clk) begin
      if (rst) begin
         exec_start <= 1'b0;
         exec_abort <= 1'b0;
      end else begin
         exec_start <= go_w && state_q == CSF_RECEPTION && !expect_q; // RL4
         exec_abort <= cr_w && state_q == CSF_EXECUTION;
      end
   end

   // status valid drops for one cycle after each data write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sv_q      <= 1'b0;
         sv_p_q    <= 1'b0;
         avail_p_q <= 1'b0;
         rdy_p_q   <= 1'b0;
      end else begin
         sv_q      <= !data_wr;
         sv_p_q    <= sv_q;
         avail_p_q <= avail_q;
         rdy_p_q   <= cmd_rdy;
      end
   end

   // ==========================================
   // buffer ports: host side writes command, reads response
   assign bif.a_we    = take_byte;
   assign bif.a_addr  = take_byte ? (cmd_rdy ? '0 : cnt_q[BUF_AW-1:0])
                                  : rptr_q[BUF_AW-1:0];
   assign bif.a_wdata = reg_wdata[7:0];
   assign bif.b_we    = exec_mem_we;
   assign bif.b_addr  = exec_mem_addr;
   assign bif.b_wdata = exec_mem_wdata;
   assign exec_mem_rdata = bif.b_rdata;

   // ==========================================
   // interrupt settings, one copy shared by all localities
   assign ack     = reg_wr && hit(reg_addr, CSF_REG_CAUSE);     // RL21
   assign ien_chg = reg_wr && hit(reg_addr, CSF_REG_IEN) &&
                    (reg_wdata[CSF_IEN_MASTER] != ien_q[CSF_IEN_MASTER]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ien_q <= CSF_IEN_RST;                                  // RL19 RL24
         ch_q  <= '0;
      end else begin
         if (reg_wr && hit(reg_addr, CSF_REG_IEN)) begin
            ien_q <= reg_wdata & CSF_IEN_WMASK;                 // RL18
         end
         if (reg_wr && hit(reg_addr, CSF_REG_VEC)) begin
            ch_q <= reg_wdata[3:0];                             // RL23
         end
      end
   end

   // cause events, each gated by its enable
   always_comb begin
      ev = '0;
      ev[CSF_IRQ_RESP]   = avail_q && !avail_p_q && sv_q;       // RL25 RL17
      ev[CSF_IRQ_STSV]   = sv_q && !sv_p_q;
      ev[CSF_IRQ_OWNER]  = owner_grant && owner_delayed;        // RL26 RL17
      ev[CSF_IRQ_CMDRDY] = cmd_rdy && !rdy_p_q;
      ev = ev & ien_q[7:0] & CSF_CAUSE_MASK;
   end

   // write-one-to-clear, a new event wins over the clear
   assign cause_d = (cause_q & ~(ack ? reg_wdata[7:0] : 8'h00)) | ev; // RL14 RL12

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cause_q <= '0;                                         // RL27
      end else begin
         cause_q <= cause_d;
      end
   end

   // one outstanding irq, cleared by an acknowledge or while master enable is 0 or changing; only an acknowledge with causes left re-arms it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_act_q <= 1'b0;                                     // RL27
         rearm_q   <= 1'b0;
      end else begin
         rearm_q <= ack && (|cause_d);                          // RL15
         if (!ien_q[CSF_IEN_MASTER] || ien_chg) begin
            irq_act_q <= 1'b0;                                  // RL19
         end else if (ack) begin
            irq_act_q <= 1'b0;                                  // RL13
         end else if (!irq_act_q && (rearm_q || |(cause_d & ~cause_q))) begin
            irq_act_q <= 1'b1;                                  // RL12 RL15
         end
      end
   end

   // ==========================================
   // register read path, answer two cycles after the request
   always_comb begin
      rd_val = '0;
      unique case (reg_addr)
         CSF_REG_IEN:   rd_val = ien_q;
         CSF_REG_CAUSE: rd_val = {24'h00_0000, cause_q};
         CSF_REG_VEC:   rd_val = {28'h000_0000, ch_q};
         CSF_REG_CAP:   rd_val = CSF_CAPS;                      // RL18 RL17
         CSF_REG_STS: begin
            rd_val[CSF_STS_EXPECT] = expect_q;
            rd_val[CSF_STS_AVAIL]  = avail_q;
            rd_val[CSF_STS_CMDRDY] = cmd_rdy;
            rd_val[CSF_STS_VALID]  = sv_q;
         end
         CSF_REG_DATA:  rd_val = {24'h00_0000, CSF_EMPTY_BYTE}; // RL3
         default:       rd_val = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd1_q      <= 1'b0;
         rd1_mem_q  <= 1'b0;
         rd1_val_q  <= '0;
         reg_rvalid <= 1'b0;
         reg_rdata  <= '0;
      end else begin
         rd1_q      <= reg_rd;
         rd1_mem_q  <= rd_byte;
         rd1_val_q  <= rd_val;
         reg_rvalid <= rd1_q;
         reg_rdata  <= rd1_mem_q ? {24'h00_0000, bif.a_rdata} : rd1_val_q;
      end
   end

   // ==========================================
   // link domain: reset, config and irq level crossing
   logic       lk_rst_s1;
   logic       lk_rst_q;
   logic [6:0] lk_s1;
   logic [6:0] lk_s2;
   logic       sirq_s1;
   logic       sirq_s2;
   logic [2:0] lo_cnt_q;
   logic       in_frame_q;
   logic [1:0] phase_q;
   logic [4:0] slot_q;
   logic       lk_lvl;

   always_ff @(posedge sirq_clk) begin
      lk_rst_s1 <= rst;
      lk_rst_q  <= lk_rst_s1;
      lk_s1     <= {irq_act_q, ien_q[CSF_IEN_TRIG +: 2], ch_q};
      lk_s2     <= lk_s1;
      sirq_s1   <= sirq_in;
      sirq_s2   <= sirq_s1;
   end

   // low levels and falling edge drive the line low when active
   assign lk_lvl = (lk_s2[5:4] == CSF_TRIG_LOW || lk_s2[5:4] == CSF_TRIG_FALL) ?
                   !lk_s2[6] : lk_s2[6];                        // RL24

   // frame tracking: start pulse, then three-clock slots
   always_ff @(posedge sirq_clk) begin
      if (lk_rst_q) begin
         lo_cnt_q   <= '0;
         in_frame_q <= 1'b0;
         phase_q    <= '0;
         slot_q     <= '0;
      end else begin
         lo_cnt_q <= sirq_s2 ? '0 :
                     (lo_cnt_q == CSF_START_MIN ? lo_cnt_q : lo_cnt_q + 3'h1);
         if (sirq_s2 && lo_cnt_q == CSF_START_MIN && !in_frame_q) begin
            in_frame_q <= 1'b1;
            phase_q    <= '0;
            slot_q     <= '0;
         end else if (in_frame_q) begin
            if (phase_q == CSF_SLOT_CLKS - 2'h1) begin
               phase_q <= '0;
               slot_q  <= slot_q + 5'h01;
               if (slot_q == CSF_NUM_SLOTS - 5'h01) begin
                  in_frame_q <= 1'b0;                           // RL16
               end
            end else begin
               phase_q <= phase_q + 2'h1;
            end
         end
      end
   end

   // drive own slot: sample phase carries the level, recovery drives high
   always_ff @(posedge sirq_clk) begin
      if (lk_rst_q) begin
         sirq_oe  <= 1'b0;
         sirq_out <= 1'b1;
      end else begin
         sirq_oe  <= in_frame_q && lk_s2[3:0] != 4'h0 &&
                     slot_q == {1'b0, lk_s2[3:0]} && phase_q != 2'h2; // RL23 RL16
         sirq_out <= (phase_q == 2'h0) ? lk_lvl : 1'b1;
      end
   end

   // ==========================================
   // checks
   sequence s_empty_rd;
      reg_rd && hit(reg_addr, CSF_REG_DATA) && !avail_q;
   endsequence
   sequence s_ack_left;
      ack && (|cause_d) && ien_q[CSF_IEN_MASTER] && !ien_chg ##1
      !ien_chg && !ack;
   endsequence

   a_empty_read_ff: assert property (@(posedge core_clk) disable iff (rst) // RL3
      s_empty_rd |=> ##1 (reg_rvalid && reg_rdata == 32'h0000_00ff))
      else $error("empty data read did not return ff");
   a_go_starts_exec: assert property (@(posedge core_clk) disable iff (rst) // RL4
      (go_w && state_q == CSF_RECEPTION && !expect_q) |=>
      (state_q == CSF_EXECUTION && exec_start))
      else $error("go did not start execution");
   a_abort_to_idle: assert property (@(posedge core_clk) disable iff (rst) // RL5
      abort |=> (state_q == CSF_IDLE && !avail_q && !expect_q))
      else $error("abort did not reach idle");
   a_done_completes: assert property (@(posedge core_clk) disable iff (rst) // RL6
      (state_q == CSF_EXECUTION && exec_done && !cr_w) |=>
      (state_q == CSF_COMPLETION && avail_q))
      else $error("finished command did not complete");
   a_multi_ignored: assert property (@(posedge core_clk) disable iff (rst) // RL11
      (multi && !exec_done && !data_wr && !data_rd) |=>
      ($stable(state_q) && $stable(avail_q) && $stable(expect_q)))
      else $error("multi-bit status write changed state");
   a_resend_rewind: assert property (@(posedge core_clk) disable iff (rst) // RL8
      (rr_w && state_q == CSF_COMPLETION) |=> (avail_q && rptr_q == '0))
      else $error("retry did not rewind response");
   a_last_read_clr: assert property (@(posedge core_clk) disable iff (rst) // RL9
      (last_rd && !wr_sts) |=> (!avail_q && state_q == CSF_COMPLETION))
      else $error("last response byte left data available");
   a_master_gate: assert property (@(posedge core_clk) disable iff (rst) // RL19
      (!ien_q[CSF_IEN_MASTER] || ien_chg) |=> !irq_act_q)
      else $error("irq active while master enable off or changing");
   a_ack_rearm: assert property (@(posedge core_clk) disable iff (rst) // RL15
      s_ack_left |=> irq_act_q)
      else $error("remaining causes did not re-raise irq");
   a_slot_off: assert property (@(posedge sirq_clk) disable iff (lk_rst_q) // RL23
      (lk_s2[3:0] == 4'h0) [*2] |-> !sirq_oe)
      else $error("serial irq driven with channel zero");
endmodule : csf_top

// ==== verif/csf_sirq_host.sv ====
// serial irq host model: frames the link clock and resolves the wire
`timescale 1ns/1ps
module csf_sirq_host (
   input  wire logic sirq_out,
   input  wire logic sirq_oe,
   output logic      sirq_clk,
   output logic      sirq_in,
   output logic      saw_low
);
   logic host_low;
   // pull-up wins while nobody drives; host start pulse overrides
   assign sirq_in = host_low ? 1'b0 : (sirq_oe ? sirq_out : 1'b1);
   // remember any slot where the device pulled the line low
   always @(posedge sirq_clk) begin
      if (sirq_oe === 1'b1 && sirq_out === 1'b0) saw_low <= 1'b1;
   end
   // frame: 6-clock start, then 54 more clocks, clock still between frames
   initial begin
      saw_low  = 1'b0;
      sirq_clk = 1'b0;
      host_low = 1'b0;
      forever begin
         for (int i = 0; i < 60; i++) begin
            host_low = (i < 6);
            #3 sirq_clk = 1'b1;
            #3 sirq_clk = 1'b0;
         end
         #41;
      end
   end
endmodule : csf_sirq_host

// ==== verif/csf_top_tb.sv ====
// self-checking bench for the command status block
`timescale 1ns/1ps
module csf_top_tb import csf_pkg::*;;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        exec_done = 1'b0;
   logic [2:0]  reg_addr = 3'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic        reg_rvalid, exec_start, exec_abort, sirq_clk, sirq_in, sirq_out, sirq_oe, saw_low;
   logic        mem_we = 1'b0;
   logic [7:0]  mem_addr = 8'h00;
   logic [7:0]  mem_wdata = 8'h00;
   logic [7:0]  exec_mem_rdata;
   int          mismatches, checked, starts, aborts, cycles;

   always #4 core_clk = ~core_clk;
   // start pulse count and watchdog
   always @(posedge core_clk) begin
      cycles++;
      if (exec_start === 1'b1) starts++;
      if (exec_abort === 1'b1) aborts++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test();
      end
   end

   csf_top dut_u (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .exec_done(exec_done), .exec_resp_len(9'h002),
      .exec_start(exec_start), .exec_abort(exec_abort), .exec_mem_we(mem_we),
      .exec_mem_addr(mem_addr), .exec_mem_wdata(mem_wdata), .exec_mem_rdata(exec_mem_rdata),
      .owner_grant(1'b0), .owner_delayed(1'b0),
      .sirq_clk(sirq_clk), .sirq_in(sirq_in), .sirq_out(sirq_out), .sirq_oe(sirq_oe));
   csf_sirq_host host_u (.sirq_out(sirq_out), .sirq_oe(sirq_oe), .sirq_clk(sirq_clk),
      .sirq_in(sirq_in), .saw_low(saw_low));

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr
   // read, answer expected two cycles after the request edge
   task automatic rd(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
      @(negedge core_clk);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      chk({reg_rvalid, reg_rdata & m}, {1'b1, e});
   endtask : rd
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end
      else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // main sequence: command flow, then response and interrupt
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      rd(CSF_REG_IEN, 32'hffff_ffff, 32'h0000_0008);
      rd(CSF_REG_DATA, 32'h0000_00ff, 32'h0000_00ff);
      wr(CSF_REG_STS, 32'h0000_0040);
      for (int i = 0; i < 6; i++) wr(CSF_REG_DATA, (i == 5) ? 32'h0000_0007 : 32'h0000_0000);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0008);
      wr(CSF_REG_DATA, 32'h0000_0055);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0000);
      wr(CSF_REG_DATA, 32'h0000_0066);
      wr(CSF_REG_STS, 32'h0000_0022);
      wr(CSF_REG_STS, 32'h0000_0002);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0000);
      chk(33'(starts), 33'h0_0000_0000);
      wr(CSF_REG_STS, 32'h0000_0020);
      repeat (2) @(negedge core_clk);
      chk(33'(starts), 33'h0_0000_0001);
      $display("command test done");
      wr(CSF_REG_VEC, 32'h0000_0003);
      wr(CSF_REG_IEN, 32'h8000_0009);
      chk({32'h0000_0000, saw_low}, 33'h0_0000_0000);
      @(negedge core_clk);
      mem_we    = 1'b1;
      mem_wdata = 8'ha5;
      @(negedge core_clk);
      mem_addr  = 8'h01;
      mem_wdata = 8'h3c;
      @(negedge core_clk);
      mem_we    = 1'b0;
      exec_done = 1'b1;
      @(negedge core_clk);
      exec_done = 1'b0;
      chk({25'h000_0000, exec_mem_rdata}, 33'h0_0000_003c);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0010);
      rd(CSF_REG_CAUSE, 32'h0000_00ff, 32'h0000_0001);
      repeat (120) @(negedge core_clk);
      chk({32'h0000_0000, saw_low}, 33'h0_0000_0001);
      rd(CSF_REG_DATA, 32'h0000_00ff, 32'h0000_00a5);
      rd(CSF_REG_DATA, 32'h0000_00ff, 32'h0000_003c);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0000);
      wr(CSF_REG_CAUSE, 32'h0000_0000);
      rd(CSF_REG_CAUSE, 32'h0000_00ff, 32'h0000_0001);
      wr(CSF_REG_CAUSE, 32'h0000_0001);
      rd(CSF_REG_CAUSE, 32'h0000_00ff, 32'h0000_0000);
      wr(CSF_REG_STS, 32'h0000_0002);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0010);
      rd(CSF_REG_CAUSE, 32'h0000_00ff, 32'h0000_0001);
      rd(CSF_REG_DATA, 32'h0000_00ff, 32'h0000_00a5);
      wr(CSF_REG_STS, 32'h0000_0040);
      rd(CSF_REG_STS, 32'h0000_0018, 32'h0000_0000);
      rd(CSF_REG_DATA, 32'h0000_00ff, 32'h0000_00ff);
      wr(CSF_REG_STS, 32'h0000_0040);
      for (int i = 0; i < 6; i++) wr(CSF_REG_DATA, (i == 5) ? 32'h0000_0006 : 32'h0000_0000);
      wr(CSF_REG_STS, 32'h0000_0020);
      wr(CSF_REG_STS, 32'h0000_0040);
      @(negedge core_clk);
      chk(33'(aborts), 33'h0_0000_0001);
      $display("response and interrupt test done");
      end_of_test();
   end
endmodule : csf_top_tb
